// file: core/lgp_pin_cell.sv
// one multi-function pin: general I/O or light driver, plus input sync
`timescale 1ns/1ps
module lgp_pin_cell (
   input  wire logic clk,
   input  wire logic pad_in,     // level seen on the pin
   input  wire logic hold,       // keep pin released (strap window)
   input  wire logic gp_pp,      // 1 = push-pull, 0 = open-drain
   input  wire logic gp_dir,     // 1 = output
   input  wire logic gp_data,
   input  wire logic light_sel,  // pin runs the light function
   input  wire logic light_pp,   // light push-pull drive
   input  wire logic light_lo,   // open light is active low
   input  wire logic light_on,
   output logic      pad_out,
   output logic      pad_oe,
   output logic      in_sync     // pin level after two flops
);

   logic sync1_r;
   logic sync2_r;

   // ****************************************************************
   // input synchroniser: first flop is read only by the second
   // ****************************************************************
   // no reset here so a held reset already fills the chain
   always_ff @(posedge clk) begin
      sync1_r <= pad_in;
      sync2_r <= sync1_r;
   end
   assign in_sync = sync2_r;

   // ****************************************************************
   // output buffer selection
   // ****************************************************************
   always_comb begin
      pad_out = 1'b0;
      pad_oe  = 1'b0;
      if (hold) begin
         pad_oe = 1'b0;              // strap must be readable
      end else if (light_sel) begin
         if (light_pp) begin
            pad_out = light_on;
            pad_oe  = 1'b1;
         end else begin              // open-drain or open-source
            pad_out = ~light_lo;
            pad_oe  = light_on;
         end
      end else if (gp_dir) begin
         if (gp_pp) begin
            pad_out = gp_data;
            pad_oe  = 1'b1;
         end else begin
            pad_out = 1'b0;
            pad_oe  = ~gp_data;      // only pulls low
         end
      end
   end

endmodule : lgp_pin_cell

// file: core/lgp_pin_select.sv
// pin select top: APB registers, strap capture and three pin cells
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module lgp_pin_select (
   input  wire logic        clk,
   input  wire logic        reset_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // light function level from the light logic
   input  wire logic        status_light_five,
   // pins: index 0 five (shares strap), 1 six, 2 seven
   input  wire logic [2:0]  pin_in,
   output logic [2:0]       pin_out,
   output logic [2:0]       pin_oe,
   // strap results for the rest of the switch
   output logic             phy_address_strap,
   output logic             phy_addr_select
);

   localparam int N = lgp_pkg::PIN_COUNT;

   logic [N-1:0]              pp_r;
   logic [N-1:0]              dir_r;
   logic [N-1:0]              data_r;
   logic [lgp_pkg::FUNC_W-1:0] func_r;
   logic                      light_en_r;
   logic                      strap_r;
   logic                      soft_r;
   logic [1:0]                wait_r;
   logic                      hold;
   logic                      capture;
   logic [N-1:0]              in_sync;
   logic [31:0]               rdata_nxt;
   logic [31:0]               prdata_r;
   logic                      err_nxt;
   logic                      err_r;
   logic                      setup;
   logic                      wr;
   logic                      light_pp;

   // ****************************************************************
   // APB decode
   // ****************************************************************
   // one wait-free access: read data is fetched in the setup cycle
   assign setup   = psel & ~penable;
   assign wr      = psel & penable & pwrite;
   assign pready  = psel & penable;
   assign pslverr = pready & err_r;
   assign prdata  = prdata_r;

   // read mux and unmapped-address check
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      err_nxt   = 1'b0;
      case (paddr)
         lgp_pkg::PIN_CFG_OFS: begin
            rdata_nxt[N-1:0] = pp_r;
         end
         lgp_pkg::PIN_DATA_OFS: begin
            rdata_nxt[lgp_pkg::DATA_OUT_LSB +: N] = data_r;
            rdata_nxt[lgp_pkg::DATA_IN_LSB +: N]  = in_sync;
            rdata_nxt[lgp_pkg::DIR_LSB +: N]      = dir_r;
         end
         lgp_pkg::LIGHT_CFG_OFS: begin
            rdata_nxt[lgp_pkg::FUNC_LSB +: lgp_pkg::FUNC_W] = func_r;
            rdata_nxt[lgp_pkg::LIGHT_EN_BIT] = light_en_r;
         end
         lgp_pkg::STRAP_OFS: begin
            rdata_nxt[lgp_pkg::STRAP_BIT] = strap_r;
            rdata_nxt[lgp_pkg::SOFT_BIT]  = soft_r;
         end
         default: begin
            err_nxt = 1'b1;
         end
      endcase
   end

   // read data and error are held from setup through the access
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         prdata_r <= 32'h0000_0000;
         err_r    <= 1'b0;
      end else if (setup) begin
         prdata_r <= pwrite ? 32'h0000_0000 : rdata_nxt;
         err_r    <= err_nxt;
      end
   end

   // ****************************************************************
   // general I/O configuration registers
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pp_r   <= lgp_pkg::PIN_PP_RST;
         dir_r  <= lgp_pkg::PIN_DIR_RST;
         data_r <= lgp_pkg::PIN_DATA_RST;
      end else if (wr && paddr == lgp_pkg::PIN_CFG_OFS) begin
         pp_r <= pwdata[N-1:0];
      end else if (wr && paddr == lgp_pkg::PIN_DATA_OFS) begin
         data_r <= pwdata[lgp_pkg::DATA_OUT_LSB +: N];
         dir_r  <= pwdata[lgp_pkg::DIR_LSB +: N];
      end
   end

   // ****************************************************************
   // light configuration register
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         func_r     <= lgp_pkg::FUNC_RST;
         light_en_r <= lgp_pkg::LIGHT_EN_RST;
      end else if (wr && paddr == lgp_pkg::LIGHT_CFG_OFS) begin
         func_r     <= pwdata[lgp_pkg::FUNC_LSB +: lgp_pkg::FUNC_W];
         light_en_r <= pwdata[lgp_pkg::LIGHT_EN_BIT];
      end
   end

   // ****************************************************************
   // strap capture after reset release
   // ****************************************************************
   // pins stay released while the window runs so the pull resistor
   // sets the level; the same reset covers power-on and the pin reset
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wait_r <= lgp_pkg::STRAP_WAIT;
      end else if (wait_r != 2'h0) begin
         wait_r <= wait_r - 2'h1;
      end
   end
   assign hold    = (wait_r != 2'h0);
   assign capture = (wait_r == 2'h1);

   // strap and soft-strap; a software write of the soft bit loses to
   // the capture only in the single capture cycle
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         strap_r <= 1'b0;
         soft_r  <= 1'b0;
      end else if (capture) begin
         strap_r <= in_sync[0];
         soft_r  <= in_sync[0];
      end else if (wr && paddr == lgp_pkg::STRAP_OFS) begin
         soft_r <= pwdata[lgp_pkg::SOFT_BIT];
      end
   end
   assign phy_address_strap = strap_r;
   assign phy_addr_select   = soft_r;

   // ****************************************************************
   // pin cells
   // ****************************************************************
   assign light_pp = lgp_pkg::light_is_pp(func_r);

   generate
      for (genvar i = 0; i < N; i++) begin : g_pin
         lgp_pin_cell u_cell (
            .clk       (clk),
            .pad_in    (pin_in[i]),
            .hold      (hold),
            .gp_pp     (pp_r[i]),
            .gp_dir    (dir_r[i]),
            .gp_data   (data_r[i]),
            .light_sel ((i == 0) ? light_en_r : 1'b0),
            .light_pp  (light_pp),
            .light_lo  (strap_r),
            .light_on  (status_light_five),
            .pad_out   (pin_out[i]),
            .pad_oe    (pin_oe[i]),
            .in_sync   (in_sync[i])
         );
      end
   endgenerate

   // ****************************************************************
   // checks
   // ****************************************************************
   sequence s_release;
      !reset_n ##1 reset_n;
   endsequence

   sequence s_pin_written;
      wr && paddr == lgp_pkg::PIN_DATA_OFS && pwdata[9];
   endsequence

   // dedicated pin six set as input never drives
   property p_six_input;
      @(posedge clk) disable iff (!reset_n)
      !hold && !dir_r[1] |-> !pin_oe[1];
   endproperty
   a_six_input: assert property (p_six_input)
      else $error("pin six driven while input");

   // a write making pin six a push-pull output shows next cycle
   property p_six_pp;
      @(posedge clk) disable iff (!reset_n)
      s_pin_written ##0 pp_r[1] && !hold
      |=> pin_oe[1] && pin_out[1] == $past(pwdata[1]);
   endproperty
   a_six_pp: assert property (p_six_pp)
      else $error("pin six push-pull output wrong");

   // enabled light in push-pull mode follows the light level
   property p_light_route;
      @(posedge clk) disable iff (!reset_n)
      !hold && light_en_r && light_pp
      |-> pin_oe[0] && pin_out[0] == status_light_five;
   endproperty
   a_light_route: assert property (p_light_route)
      else $error("light not routed to pin five");

   // light disabled: open-drain general output pulls low on zero
   property p_five_gpio;
      @(posedge clk) disable iff (!reset_n)
      !hold && !light_en_r && dir_r[0] && !pp_r[0]
      |-> pin_oe[0] == !data_r[0] && !pin_out[0];
   endproperty
   a_five_gpio: assert property (p_five_gpio)
      else $error("pin five not acting as general output");

   // open drive never drives the inactive level
   property p_light_open;
      @(posedge clk) disable iff (!reset_n)
      !hold && light_en_r && !light_pp
      |-> pin_oe[0] == status_light_five && pin_out[0] != strap_r;
   endproperty
   a_light_open: assert property (p_light_open)
      else $error("open light drive level wrong");

   // active-high open-source light drives high while lit
   property p_light_pol;
      @(posedge clk) disable iff (!reset_n)
      !hold && light_en_r && !light_pp && !strap_r && status_light_five
      |-> pin_oe[0] && pin_out[0];
   endproperty
   a_light_pol: assert property (p_light_pol)
      else $error("light polarity not from strap");

   // soft-strap default equals the sampled strap
   property p_soft_default;
      @(posedge clk) disable iff (!reset_n)
      capture |=> soft_r == strap_r && strap_r == $past(in_sync[0]);
   endproperty
   a_soft_default: assert property (p_soft_default)
      else $error("soft-strap default not loaded");

   // strap window ends two cycles after release, pins released
   property p_strap_window;
      @(posedge clk)
      s_release |-> (hold && pin_oe == 3'h0) [*2] ##1 !hold;
   endproperty
   a_strap_window: assert property (p_strap_window)
      else $error("strap window length wrong");

   // dedicated pin seven as open-drain output only ever pulls low
   property p_seven_open;
      @(posedge clk) disable iff (!reset_n)
      !hold && dir_r[2] && !pp_r[2]
      |-> pin_oe[2] == !data_r[2] && !pin_out[2];
   endproperty
   a_seven_open: assert property (p_seven_open)
      else $error("pin seven open-drain drive wrong");

   // light disabled: push-pull general output follows its data bit
   property p_five_pp;
      @(posedge clk) disable iff (!reset_n)
      !hold && !light_en_r && dir_r[0] && pp_r[0]
      |-> pin_oe[0] && pin_out[0] == data_r[0];
   endproperty
   a_five_pp: assert property (p_five_pp)
      else $error("pin five push-pull output wrong");

   sequence s_light_written;
      wr && paddr == lgp_pkg::LIGHT_CFG_OFS
      && pwdata[lgp_pkg::LIGHT_EN_BIT]
      && pwdata[lgp_pkg::FUNC_LSB + lgp_pkg::FUNC_W - 1];
   endsequence

   // enabling the light with an upper function code drives next cycle
   property p_light_push;
      @(posedge clk) disable iff (!reset_n)
      s_light_written ##0 !hold |=> pin_oe[0];
   endproperty
   a_light_push: assert property (p_light_push)
      else $error("push-pull light not driven after enable");

   // active-low open-drain light pulls low only while lit
   property p_light_lo;
      @(posedge clk) disable iff (!reset_n)
      !hold && light_en_r && !light_pp && strap_r
      |-> pin_oe[0] == status_light_five && !pin_out[0];
   endproperty
   a_light_lo: assert property (p_light_lo)
      else $error("active-low light drive wrong");

   // a soft-strap write outside the capture cycle is kept
   property p_soft_write;
      @(posedge clk) disable iff (!reset_n)
      wr && paddr == lgp_pkg::STRAP_OFS && !capture
      |=> soft_r == $past(pwdata[lgp_pkg::SOFT_BIT]);
   endproperty
   a_soft_write: assert property (p_soft_write)
      else $error("soft-strap write lost");

   // the sampled strap only moves in the capture cycle; a later pin
   // level must never leak into it
   property p_strap_held;
      @(posedge clk) disable iff (!reset_n)
      !capture |=> $stable(strap_r);
   endproperty
   a_strap_held: assert property (p_strap_held)
      else $error("strap changed outside capture");

endmodule : lgp_pin_select

// file: pkg/lgp_pkg.sv
// constants and helpers shared by the pin select block
//
// Function
// - dedicated pins: push-pull, open-drain or input
// - enable bit routes light five to shared pin
// - enable clear makes shared pin general I/O
// - function field picks light buffer type
// - open-drain light polarity follows sampled strap
// - sampled strap loads PHY address soft-strap default
// - strap latched once, two cycles after reset release
package lgp_pkg;

   // ****************************************************************
   // register map (byte addresses)
   // ****************************************************************
   localparam logic [7:0] PIN_CFG_OFS   = 8'h00; // buffer type per pin
   localparam logic [7:0] PIN_DATA_OFS  = 8'h04; // data and direction
   localparam logic [7:0] LIGHT_CFG_OFS = 8'h08; // light_config_reg
   localparam logic [7:0] STRAP_OFS     = 8'h0C; // strap and soft-strap

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int PIN_COUNT     = 3;  // five, six, seven
   localparam int DATA_OUT_LSB  = 0;  // output data bits
   localparam int DATA_IN_LSB   = 4;  // pin levels, read only
   localparam int DIR_LSB       = 8;  // 1 = output
   localparam int FUNC_LSB      = 0;  // light_function_field
   localparam int FUNC_W        = 3;
   localparam int LIGHT_EN_BIT  = 8;  // status_light_five enable
   localparam int STRAP_BIT     = 0;  // sampled phy_address_strap
   localparam int SOFT_BIT      = 1;  // phy address select soft-strap

   // ****************************************************************
   // reset values and timing
   // ****************************************************************
   localparam logic [2:0] PIN_PP_RST   = 3'h0; // open-drain at reset
   localparam logic [2:0] PIN_DIR_RST  = 3'h0; // inputs at reset
   localparam logic [2:0] PIN_DATA_RST = 3'h7;
   localparam logic [2:0] FUNC_RST     = 3'h0;
   localparam logic       LIGHT_EN_RST = 1'b0;
   // cycles after release before the strap is taken: sync depth
   localparam logic [1:0] STRAP_WAIT   = 2'h2;

   // ****************************************************************
   // decoding used by the datapath and its checks
   // ****************************************************************
   // upper code half of the function field selects push-pull drive
   function automatic logic light_is_pp(input logic [FUNC_W-1:0] f);
      return f[FUNC_W-1];
   endfunction : light_is_pp

endpackage : lgp_pkg

// file: test/led_gpio_pin_select_test.sv
// self-checking bench for the pin select block
`timescale 1ns/1ps
module led_gpio_pin_select_test;
   // ****************************************************************
   // signals and model state
   // ****************************************************************
   logic        clk;
   logic        reset_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        status_light_five;
   logic [2:0]  ext_r;
   logic [2:0]  pin_in;
   logic [2:0]  pin_out;
   logic [2:0]  pin_oe;
   logic        phy_address_strap;
   logic        phy_addr_select;
   int          fails;
   int          total_checks;
   int          m_cfg, m_dat, m_dir, m_fun, m_en, m_strap, m_soft;
   logic [31:0] seed = 32'hE753;

   // wire level: a driving pin wins over the outside world
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_r);

   lgp_pin_select i_lgp_pin_select (
      .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .status_light_five(status_light_five), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe),
      .phy_address_strap(phy_address_strap),
      .phy_addr_select(phy_addr_select));

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [31:0] xorshift();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xorshift

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one transfer; waits for pready, only the watchdog ends a wait
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] x,
                     input logic ex);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, x);
      chk({31'h0, e}, {31'h0, ex});
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask : wr

   // expected pin drive from the model, then the data register readback
   task automatic chk_pins();
      logic [2:0] eo;
      logic [2:0] eu;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 3; i++) begin
         eo[i] = m_dir[i] & (m_cfg[i] | ~m_dat[i]);
         eu[i] = m_dat[i];
      end
      if (m_en[0]) begin
         eo[0] = m_fun[2] ? 1'b1 : status_light_five;
         eu[0] = m_fun[2] ? status_light_five : ~m_strap[0];
      end
      chk({29'h0, pin_oe}, {29'h0, eo});
      chk({29'h0, pin_out & eo}, {29'h0, eu & eo});
      rd(lgp_pkg::PIN_DATA_OFS, (m_dir << 8) | (((eo & eu) |
         (~eo & ext_r)) << 4) | m_dat, 1'b0);
   endtask : chk_pins

   // reset with a given strap level, then reset values and soft-strap
   task automatic do_reset(input logic s);
      ext_r[0] <= s;
      reset_n  <= 1'b0;
      repeat (12) @(posedge clk);
      chk({29'h0, pin_oe}, 32'h0);
      reset_n <= 1'b1;
      m_cfg   = 0;
      m_dat   = 7;
      m_dir   = 0;
      m_fun   = 0;
      m_en    = 0;
      m_strap = int'(s);
      m_soft  = int'(s);
      repeat (4) @(posedge clk);
      rd(lgp_pkg::PIN_CFG_OFS, 32'h0, 1'b0);
      rd(lgp_pkg::LIGHT_CFG_OFS, 32'h0, 1'b0);
      rd(lgp_pkg::STRAP_OFS, {30'h0, s, s}, 1'b0);
      chk({30'h0, phy_address_strap, phy_addr_select}, {30'h0, s, s});
      wr(lgp_pkg::STRAP_OFS, {30'h0, ~s, ~s});
      m_soft = int'(~s);
      rd(lgp_pkg::STRAP_OFS, {30'h0, m_soft[0], s}, 1'b0);
      chk({31'h0, phy_addr_select}, {31'h0, m_soft[0]});
      chk_pins();
   endtask : do_reset

   // every function code with the light off and on
   task automatic light_sweep();
      for (int f = 0; f < 8; f++) begin
         for (int l = 0; l < 2; l++) begin
            m_en  = 1;
            m_fun = f;
            wr(lgp_pkg::LIGHT_CFG_OFS, 32'h100 | f);
            status_light_five <= l[0];
            chk_pins();
            rd(lgp_pkg::LIGHT_CFG_OFS, 32'h100 | f, 1'b0);
         end
      end
   endtask : light_sweep

   // ****************************************************************
   // clock, watchdog and main sequence
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // the whole run is about 660 cycles; this is ample margin
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      tally_and_finish();
   end

   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      logic [31:0] r;
      {reset_n, psel, penable, pwrite, status_light_five} = 5'h0;
      {paddr, pwdata, ext_r} = '0;
      fails = 0;
      total_checks = 0;
      @(posedge clk);
      do_reset(1'b1);
      // random general I/O setups on all three pins
      for (int k = 0; k < 12; k++) begin
         r = xorshift();
         {m_cfg, m_dat, m_dir} = {int'(r[2:0]), int'(r[6:4]), int'(r[10:8])};
         ext_r <= r[14:12];
         wr(lgp_pkg::PIN_CFG_OFS, {29'h0, r[2:0]});
         wr(lgp_pkg::PIN_DATA_OFS, {21'h0, r[10:8], 5'h0, r[6:4]});
         chk_pins();
         rd(lgp_pkg::PIN_CFG_OFS, {29'h0, r[2:0]}, 1'b0);
      end
      light_sweep();
      // enable cleared: pin five falls back to its general I/O setup
      m_en = 0;
      wr(lgp_pkg::LIGHT_CFG_OFS, 32'h0);
      chk_pins();
      // unmapped place: refused, reads zero, nothing disturbed
      wr(8'h10, 32'hFFFF_FFFF);
      rd(8'h10, 32'h0, 1'b1);
      chk_pins();
      do_reset(1'b0);
      light_sweep();
      tally_and_finish();
   end
endmodule : led_gpio_pin_select_test
